// File: hdl/ies_top.sv
/*
 i2c event flags, interrupt arbiter and wired-and serial clock generator.
 assumes apb master on mclk, event strobes from same-clock controller logic,
 and open-drain scl/sda pins resolved outside.
*/
`timescale 1ns/10ps
module ies_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ies_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ies_pkg::ies_events_s ev,
   input wire logic sda_drive_low,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic master_active,
   output logic irq
);
   typedef struct packed {
      logic run;
      logic ten_bit;
      logic [6:0] own_addr;
      logic [ies_pkg::DIV_W-1:0] low_div;
      logic [ies_pkg::DIV_W-1:0] high_div;
      logic [ies_pkg::NUM_EV-1:0] flags;
      logic [ies_pkg::NUM_EV-1:0] enables;
      logic [2:0] code;
      logic master;
      ies_pkg::ies_gen_e gen;
      logic [ies_pkg::DIV_W-1:0] cnt;
      logic scl_prev;
      logic [31:0] rdata;
   } ies_state_s;

   ies_state_s st_reg;
   ies_state_s st_next;

   logic scl_s;
   logic sda_s;
   logic setup_ph;
   logic access_ph;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic src_read;
   logic scl_fell;
   logic [ies_pkg::NUM_EV-1:0] pending;
   logic [ies_pkg::NUM_EV-1:0] set_ev;

   ies_sync2 #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({scl_i, sda_i}),
      .sync_out({scl_s, sda_s})
   );

   // lowest flag index has the highest priority
   function automatic logic [2:0] pick_code(input logic [ies_pkg::NUM_EV-1:0] req);
      logic [2:0] c;
      c = ies_pkg::CODE_NONE;
      for (int i = ies_pkg::NUM_EV - 1; i >= 0; i--) begin
         if (req[i]) begin
            c = 3'(i + 1);
         end
      end
      return c;
   endfunction

   function automatic logic [ies_pkg::NUM_EV-1:0] code_bit(input logic [2:0] c);
      logic [ies_pkg::NUM_EV-1:0] b;
      b = '0;
      if (c != ies_pkg::CODE_NONE) begin
         b[c - 3'h1] = 1'b1;
      end
      return b;
   endfunction

   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign mapped = (paddr == ies_pkg::OFS_CTRL) || (paddr == ies_pkg::OFS_DIV) ||
                   (paddr == ies_pkg::OFS_FLAG) || (paddr == ies_pkg::OFS_ENABLE) ||
                   (paddr == ies_pkg::OFS_SOURCE) || (paddr == ies_pkg::OFS_STATUS);
   assign wr_acc = access_ph && pwrite && mapped;
   assign rd_acc = access_ph && !pwrite && mapped;
   assign src_read = rd_acc && (paddr == ies_pkg::OFS_SOURCE);
   assign scl_fell = st_reg.scl_prev && !scl_s;
   assign pending = st_reg.flags & st_reg.enables;

   // hardware event sources; all gated by the run bit
   always_comb begin
      set_ev = '0;
      set_ev[ies_pkg::FL_ARB_LOST] = ev.arb_lost;
      set_ev[ies_pkg::FL_NO_ACK] = ev.nack && st_reg.master && ev.master_tx;
      set_ev[ies_pkg::FL_ACCESS] = ev.access_done;
      set_ev[ies_pkg::FL_RX_READY] = ev.rx_copy;
      // ten-bit repeat transmit fires before any ack is known
      set_ev[ies_pkg::FL_TX_READY] = ev.tx_copy ||
         (ev.start_sent && st_reg.master && ev.master_tx && ev.repeat_mode &&
          st_reg.ten_bit);
      set_ev[ies_pkg::FL_STOP] = ev.stop_seen;
      set_ev[ies_pkg::FL_ADDRESSED] = ev.addr_valid &&
         ((ev.addr == st_reg.own_addr) || (ev.addr == 7'h00));
   end

   always_comb begin
      st_next = st_reg;
      st_next.scl_prev = scl_s;

      // apb writes
      if (wr_acc) begin
         case (paddr)
            ies_pkg::OFS_CTRL: begin
               st_next.run = pwdata[ies_pkg::CTRL_RUN_BIT];
               st_next.ten_bit = pwdata[ies_pkg::CTRL_TEN_BIT];
               st_next.own_addr = pwdata[ies_pkg::CTRL_OWN_LSB +: 7];
            end
            ies_pkg::OFS_DIV: begin
               st_next.low_div = pwdata[ies_pkg::DIV_LOW_LSB +: ies_pkg::DIV_W];
               st_next.high_div = pwdata[ies_pkg::DIV_HIGH_LSB +: ies_pkg::DIV_W];
            end
            ies_pkg::OFS_ENABLE: begin
               st_next.enables = pwdata[ies_pkg::NUM_EV-1:0];
            end
            default: begin
            end
         endcase
      end

      // flags: software clears first, hardware sets win
      if (wr_acc && (paddr == ies_pkg::OFS_FLAG)) begin
         st_next.flags = st_next.flags & ~pwdata[ies_pkg::NUM_EV-1:0];
      end
      if (src_read) begin
         // clear what software was shown, not what may have changed since
         st_next.flags = st_next.flags &
            ~(code_bit(st_reg.rdata[2:0]) & ~ies_pkg::READ_KEEP_MASK);
      end
      if (st_reg.run) begin
         st_next.flags = st_next.flags | set_ev;
      end

      // master mode
      if (ev.master_start && st_reg.run) begin
         st_next.master = 1'b1;
      end
      if (ev.arb_lost || ev.stop_seen) begin
         st_next.master = 1'b0;
      end

      // source code and arbiter
      if (src_read) begin
         st_next.code = ies_pkg::CODE_NONE;
      end else if (st_reg.code != ies_pkg::CODE_NONE) begin
         if ((code_bit(st_reg.code) & pending) == '0) begin
            st_next.code = ies_pkg::CODE_NONE;
         end
      end else begin
         st_next.code = pick_code(pending);
      end

      // serial clock generator
      case (st_reg.gen)
         ies_pkg::GEN_IDLE: begin
            st_next.cnt = '0;
            if (st_reg.run && st_reg.master) begin
               st_next.gen = ies_pkg::GEN_LOW;
            end
         end
         ies_pkg::GEN_LOW: begin
            st_next.cnt = st_reg.cnt + 8'h01;
            if (st_reg.cnt >= st_reg.low_div) begin
               st_next.gen = ies_pkg::GEN_WAIT;
               st_next.cnt = '0;
            end
         end
         ies_pkg::GEN_WAIT: begin
            // line may be held by a slower device or a stretching slave
            st_next.cnt = '0;
            if (scl_s) begin
               st_next.gen = ies_pkg::GEN_HIGH;
            end
         end
         ies_pkg::GEN_HIGH: begin
            st_next.cnt = st_reg.cnt + 8'h01;
            if (scl_fell) begin
               st_next.gen = ies_pkg::GEN_LOW;
               st_next.cnt = '0;
            end else if (st_reg.cnt >= st_reg.high_div) begin
               st_next.gen = ies_pkg::GEN_LOW;
               st_next.cnt = '0;
            end
         end
         default: begin
            st_next.gen = ies_pkg::GEN_IDLE;
            st_next.cnt = '0;
         end
      endcase
      if (!st_next.master) begin
         st_next.gen = ies_pkg::GEN_IDLE;
      end

      // module held off: flags default, master dropped, generator idle
      if (!st_reg.run) begin
         st_next.flags = '0;
         st_next.master = 1'b0;
         st_next.code = ies_pkg::CODE_NONE;
         st_next.gen = ies_pkg::GEN_IDLE;
         st_next.cnt = '0;
      end

      // read data is latched in the setup phase
      if (setup_ph) begin
         st_next.rdata = '0;
         case (paddr)
            ies_pkg::OFS_CTRL: begin
               st_next.rdata[ies_pkg::CTRL_RUN_BIT] = st_reg.run;
               st_next.rdata[ies_pkg::CTRL_TEN_BIT] = st_reg.ten_bit;
               st_next.rdata[ies_pkg::CTRL_OWN_LSB +: 7] = st_reg.own_addr;
            end
            ies_pkg::OFS_DIV: begin
               st_next.rdata[ies_pkg::DIV_LOW_LSB +: ies_pkg::DIV_W] = st_reg.low_div;
               st_next.rdata[ies_pkg::DIV_HIGH_LSB +: ies_pkg::DIV_W] = st_reg.high_div;
            end
            ies_pkg::OFS_FLAG: begin
               st_next.rdata[ies_pkg::NUM_EV-1:0] = st_reg.flags;
            end
            ies_pkg::OFS_ENABLE: begin
               st_next.rdata[ies_pkg::NUM_EV-1:0] = st_reg.enables;
            end
            ies_pkg::OFS_SOURCE: begin
               st_next.rdata[2:0] = st_reg.code;
            end
            ies_pkg::OFS_STATUS: begin
               st_next.rdata[ies_pkg::STAT_MASTER_BIT] = st_reg.master;
               st_next.rdata[ies_pkg::STAT_SCL_BIT] = scl_s;
               st_next.rdata[ies_pkg::STAT_SDA_BIT] = sda_s;
               st_next.rdata[ies_pkg::STAT_GEN_LSB +: 2] = st_reg.gen;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.run <= 1'b0;
         st_reg.ten_bit <= 1'b0;
         st_reg.own_addr <= ies_pkg::RST_OWN_ADDR;
         st_reg.low_div <= ies_pkg::RST_LOW_DIV;
         st_reg.high_div <= ies_pkg::RST_HIGH_DIV;
         st_reg.flags <= '0;
         st_reg.enables <= '0;
         st_reg.code <= ies_pkg::CODE_NONE;
         st_reg.master <= 1'b0;
         st_reg.gen <= ies_pkg::GEN_IDLE;
         st_reg.cnt <= '0;
         st_reg.scl_prev <= 1'b1;
         st_reg.rdata <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access_ph && !mapped;
   assign prdata = st_reg.rdata;
   assign irq = (st_reg.code != ies_pkg::CODE_NONE);
   assign master_active = st_reg.master;
   // open drain: only ever pull low
   assign scl_o = 1'b0;
   assign scl_oe = (st_reg.gen == ies_pkg::GEN_LOW);
   assign sda_o = 1'b0;
   assign sda_oe = st_reg.run && sda_drive_low;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_scl_low_restart: assert property (
      st_reg.gen == ies_pkg::GEN_HIGH && scl_fell && st_reg.run && st_reg.master &&
      !ev.arb_lost && !ev.stop_seen
      |=> st_reg.gen == ies_pkg::GEN_LOW && st_reg.cnt == '0 ##1 scl_oe)
      else $error("scl fall in high phase did not restart low count");

   a_high_waits_release: assert property (
      st_reg.gen == ies_pkg::GEN_WAIT && !scl_s |=> st_reg.gen != ies_pkg::GEN_HIGH)
      else $error("high phase began while scl still low");

   a_low_count_len: assert property (
      st_reg.gen == ies_pkg::GEN_LOW && st_reg.run && !ev.arb_lost && !ev.stop_seen
      |=> (st_reg.gen == ies_pkg::GEN_LOW) ==
      ($past(st_reg.cnt) < $past(st_reg.low_div)))
      else $error("low phase length does not match divider");

   a_stretch_stall: assert property (
      (st_reg.gen == ies_pkg::GEN_WAIT && !scl_s)[*3] |-> !scl_oe)
      else $error("generator drove scl while line was stretched");

   a_source_nonzero: assert property (
      pending != '0 && st_reg.code == ies_pkg::CODE_NONE && !src_read && st_reg.run
      |=> st_reg.code == pick_code($past(pending)) && irq)
      else $error("pending request not forwarded with right code");

   a_enable_gates: assert property (
      st_reg.code != ies_pkg::CODE_NONE |-> (code_bit(st_reg.code) & $past(pending)) != '0)
      else $error("source code names a disabled request");

   a_read_clears: assert property (
      src_read && st_reg.rdata[2:0] == 3'h1 && !ev.arb_lost
      |=> !st_reg.flags[ies_pkg::FL_ARB_LOST])
      else $error("source read did not clear arbitration flag");

   a_read_keeps: assert property (
      src_read && st_reg.rdata[2:0] == 3'h4 && st_reg.run
      |=> st_reg.flags[ies_pkg::FL_RX_READY])
      else $error("source read cleared a kept flag");

   a_rearm_after: assert property (
      src_read ##1 (pending != '0 && st_reg.run && !src_read) |=> irq)
      else $error("arbiter did not reload after source read");

   a_nack_flag: assert property (
      ev.nack && ev.master_tx && st_reg.master && st_reg.run
      |=> st_reg.flags[ies_pkg::FL_NO_ACK])
      else $error("no-ack event lost");

   a_general_call: assert property (
      ev.addr_valid && ev.addr == 7'h00 && st_reg.run |=> st_reg.flags[ies_pkg::FL_ADDRESSED])
      else $error("general call did not set addressed flag");

   a_arb_exit: assert property (
      ev.arb_lost && st_reg.run |=> !master_active && st_reg.flags[ies_pkg::FL_ARB_LOST]
      ##1 st_reg.gen == ies_pkg::GEN_IDLE)
      else $error("arbitration loss did not leave master mode");

   a_run_off: assert property (
      !st_reg.run |=> st_reg.flags == '0 && !scl_oe && !irq)
      else $error("flags or pins active while module held off");

   a_src_zero: assert property (
      pending == '0 |=> st_reg.code == ies_pkg::CODE_NONE && !irq)
      else $error("source not zero with nothing pending");

   c_stretch: cover property (
      (st_reg.gen == ies_pkg::GEN_WAIT && !scl_s) [*4] ##1 st_reg.gen == ies_pkg::GEN_HIGH);
   c_sync_restart: cover property (st_reg.gen == ies_pkg::GEN_HIGH && scl_fell);
   c_read_reload: cover property (src_read ##2 irq);
   c_arb_lost: cover property (st_reg.master && ev.arb_lost);
endmodule

// File: inc/ies_pkg.sv
/*
 i2c event logic and serial clock synchroniser: shared constants and types.
 assumes an apb slave on mclk and event strobes from the rest of the controller.
*/
// Overview of operation
// - a falling scl edge in the high phase restarts low count
// - high phase waits until scl really high
// - slowest low and fastest high shape scl
// - stretched scl low stalls our generator
// - seven events merged into one interrupt
// - flag always sets; enable gates the request
// - source read clears flag, except four flags
// - after read, arbiter loads next pending code
// - tx_ready when holding copied to shift
// - ten-bit repeat transmit: tx_ready after start
// - rx_ready when shift copied to holding
// - access ready when programmed values consumed
// - no_ack while master transmitter gets nack
// - arb_lost when arbitration contest lost
// - stop_seen on every stop condition
// - addressed when own address or general call
// - arbitration loss leaves master mode, flags
// - run bit low clears flags, releases pins
package ies_pkg;
   localparam int ADDR_W = 8;
   localparam int NUM_EV = 7;
   localparam int DIV_W = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DIV = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SOURCE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

   // control register fields
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_TEN_BIT = 1;
   localparam int CTRL_OWN_LSB = 8;
   // divider register fields
   localparam int DIV_LOW_LSB = 0;
   localparam int DIV_HIGH_LSB = 8;
   // status register fields
   localparam int STAT_MASTER_BIT = 0;
   localparam int STAT_SCL_BIT = 1;
   localparam int STAT_SDA_BIT = 2;
   localparam int STAT_GEN_LSB = 4;

   // flag bit positions, lowest index wins arbitration
   localparam int FL_ARB_LOST = 0;
   localparam int FL_NO_ACK = 1;
   localparam int FL_ACCESS = 2;
   localparam int FL_RX_READY = 3;
   localparam int FL_TX_READY = 4;
   localparam int FL_STOP = 5;
   localparam int FL_ADDRESSED = 6;
   // flags that a source read leaves set
   localparam logic [NUM_EV-1:0] READ_KEEP_MASK = 7'h5C;

   // reset values
   localparam logic [DIV_W-1:0] RST_LOW_DIV = 8'h0A;
   localparam logic [DIV_W-1:0] RST_HIGH_DIV = 8'h0A;
   localparam logic [6:0] RST_OWN_ADDR = 7'h00;
   localparam logic [2:0] CODE_NONE = 3'h0;

   typedef enum logic [1:0] {GEN_IDLE, GEN_LOW, GEN_WAIT, GEN_HIGH} ies_gen_e;

   typedef struct packed {
      logic tx_copy;
      logic rx_copy;
      logic access_done;
      logic nack;
      logic arb_lost;
      logic stop_seen;
      logic start_sent;
      logic master_start;
      logic master_tx;
      logic repeat_mode;
      logic addr_valid;
      logic [6:0] addr;
   } ies_events_s;
endpackage

// File: hdl/ies_sync2.sv
/*
 two-flop synchroniser for asynchronous levels.
 assumes the input may change at any time relative to mclk.
*/
`timescale 1ns/10ps
module ies_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } ies_sync_s;

   ies_sync_s st_reg;
   ies_sync_s st_next;

   // first stage feeds only the second stage
   always_comb begin
      st_next.ff1 = async_in;
      st_next.ff2 = st_reg.ff1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= {RST_VAL, RST_VAL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.ff2;
endmodule

// File: sim/ies_bus_model.sv
/*
 bus partner: a second clock master, or a stretching target, on the scl wire.
 assumes scl is the resolved wired-and level and mclk is the bench clock.
*/
`timescale 1ns/10ps
module ies_bus_model #(
   parameter int HALF = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic run_clk,
   input wire logic stretch,
   output logic pull_low
);
   int cnt;
   logic scl_d;
   // half period of 4 mclk cycles gives the 400 ns link clock
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         pull_low <= 1'h0;
         scl_d <= 1'h1;
      end else begin
         scl_d <= scl;
         if (stretch) begin
            pull_low <= 1'h1;
         end else if (!run_clk) begin
            pull_low <= 1'h0;
            cnt <= 0;
         end else if (scl_d && !scl && !pull_low) begin
            pull_low <= 1'h1;
            cnt <= 0;
         end else if (pull_low) begin
            cnt <= cnt + 1;
            if (cnt == HALF - 1) begin
               pull_low <= 1'h0;
               cnt <= 0;
            end
         end else if (scl) begin
            // high count only once the wire is really high
            cnt <= cnt + 1;
            if (cnt == HALF - 1) begin
               pull_low <= 1'h1;
               cnt <= 0;
            end
         end
      end
   end
endmodule

// File: sim/tb.sv
/*
 self-checking bench: event flags, arbiter and scl generator of ies_top.
 assumes the apb map and event timing of the design notes; pull-ups on both wires.
*/
`timescale 1ns/10ps
module tb;
   typedef struct {int b; logic [2:0] code; logic keep;} ies_row_s;
   logic mclk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [ies_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ies_pkg::ies_events_s ev = '0;
   ies_pkg::ies_events_s lv = '0;
   logic sda_drive_low = 1'h0;
   logic scl_oe, sda_oe, master_active, irq, p_low, scl, sda;
   logic scl_out, sda_out;
   logic run_clk = 1'h0;
   logic stretch = 1'h0;
   logic [31:0] rd;
   logic er;
   int failures = 0;
   int checks = 0;
   ies_row_s rows [7] = '{'{ies_pkg::FL_ARB_LOST, 3'h1, 1'h0},
      '{ies_pkg::FL_NO_ACK, 3'h2, 1'h0}, '{ies_pkg::FL_ACCESS, 3'h3, 1'h1},
      '{ies_pkg::FL_RX_READY, 3'h4, 1'h1}, '{ies_pkg::FL_TX_READY, 3'h5, 1'h1},
      '{ies_pkg::FL_STOP, 3'h6, 1'h0}, '{ies_pkg::FL_ADDRESSED, 3'h7, 1'h1}};
   // open drain: released lines read high through the pull-ups
   assign scl = ~(scl_oe | p_low);
   assign sda = ~sda_oe;
   always #25 mclk = ~mclk;
   ies_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ev(ev), .sda_drive_low(sda_drive_low), .scl_i(scl),
      .scl_o(scl_out), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_out), .sda_oe(sda_oe),
      .master_active(master_active), .irq(irq));
   ies_bus_model u_bus (.mclk(mclk), .rst_n(rst_n), .scl(scl), .run_clk(run_clk),
      .stretch(stretch), .pull_low(p_low));
   task stop_test;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge mclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // strobe lasts exactly one cycle, then room for flag and code to land
   task pulse(input ies_pkg::ies_events_s e);
      @(posedge mclk);
      ev <= ies_pkg::ies_events_s'(lv | e);
      @(posedge mclk);
      ev <= lv;
      repeat (3) @(posedge mclk);
   endtask
   function automatic ies_pkg::ies_events_s ev_of(input int b);
      ies_pkg::ies_events_s e;
      e = '0;
      case (b)
         ies_pkg::FL_ARB_LOST: e.arb_lost = 1'h1;
         ies_pkg::FL_NO_ACK: e.nack = 1'h1;
         ies_pkg::FL_ACCESS: e.access_done = 1'h1;
         ies_pkg::FL_RX_READY: e.rx_copy = 1'h1;
         ies_pkg::FL_TX_READY: e.tx_copy = 1'h1;
         ies_pkg::FL_STOP: e.stop_seen = 1'h1;
         default: e.addr_valid = 1'h1;
      endcase
      return e;
   endfunction
   initial begin
      #1000000;
      failures++;
      stop_test();
   end
   initial begin
      ies_pkg::ies_events_s e;
      ies_pkg::ies_events_s ms;
      int hi, lo, hi_max, lo_min;
      ms = '0;
      ms.master_start = 1'h1;
      repeat (2) @(posedge mclk);
      rst_n <= 1'h1;
      apb(1'h0, ies_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, ies_pkg::OFS_DIV, 32'h0);
      chk(rd, 32'h00000A0A);
      apb(1'h0, 8'h18, 32'h0);
      chk(er, 1'h1);
      chk(rd, 32'h0);
      apb(1'h1, ies_pkg::OFS_CTRL, 32'h1);
      apb(1'h1, ies_pkg::OFS_ENABLE, 32'h7F);
      lv.master_tx = 1'h1;
      foreach (rows[i]) begin
         apb(1'h1, ies_pkg::OFS_FLAG, 32'h7F);
         pulse(ms);
         pulse(ev_of(rows[i].b));
         chk(irq, 1'h1);
         apb(1'h0, ies_pkg::OFS_SOURCE, 32'h0);
         chk(rd, rows[i].code);
         apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
         chk(rd, 32'(rows[i].keep) << rows[i].b);
         chk(irq, rows[i].keep);
      end
      apb(1'h1, ies_pkg::OFS_FLAG, 32'h7F);
      apb(1'h1, ies_pkg::OFS_ENABLE, 32'h0);
      pulse(ev_of(ies_pkg::FL_STOP));
      apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h20);
      chk(irq, 1'h0);
      apb(1'h0, ies_pkg::OFS_SOURCE, 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, ies_pkg::OFS_ENABLE, 32'h20);
      repeat (3) @(posedge mclk);
      chk(irq, 1'h1);
      apb(1'h1, ies_pkg::OFS_ENABLE, 32'h7F);
      // a held stop code would hide the higher-priority no-ack below
      apb(1'h1, ies_pkg::OFS_FLAG, 32'h7F);
      pulse(ms);
      chk(master_active, 1'h1);
      e = '0;
      e.nack = 1'h1;
      e.stop_seen = 1'h1;
      pulse(e);
      apb(1'h0, ies_pkg::OFS_SOURCE, 32'h0);
      chk(rd, 32'h2);
      repeat (2) @(posedge mclk);
      apb(1'h0, ies_pkg::OFS_SOURCE, 32'h0);
      chk(rd, 32'h6);
      pulse(ev_of(ies_pkg::FL_NO_ACK));
      apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h0);
      pulse(ms);
      pulse(ev_of(ies_pkg::FL_ARB_LOST));
      chk(master_active, 1'h0);
      apb(1'h0, ies_pkg::OFS_SOURCE, 32'h0);
      chk(rd, 32'h1);
      apb(1'h1, ies_pkg::OFS_CTRL, 32'h5501);
      e = '0;
      e.addr_valid = 1'h1;
      e.addr = 7'h23;
      pulse(e);
      apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h0);
      e.addr = 7'h55;
      pulse(e);
      apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h40);
      apb(1'h1, ies_pkg::OFS_FLAG, 32'h7F);
      apb(1'h1, ies_pkg::OFS_CTRL, 32'h3);
      lv.repeat_mode = 1'h1;
      pulse(ms);
      e = '0;
      e.start_sent = 1'h1;
      pulse(e);
      apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h10);
      stretch <= 1'h1;
      repeat (40) @(posedge mclk);
      apb(1'h0, ies_pkg::OFS_STATUS, 32'h0);
      chk(rd[5:4], 2'h2);
      chk(scl_oe, 1'h0);
      stretch <= 1'h0;
      repeat (6) @(posedge mclk);
      apb(1'h0, ies_pkg::OFS_STATUS, 32'h0);
      chk(rd[5:4], 2'h3);
      run_clk <= 1'h1;
      repeat (40) @(posedge mclk);
      // first low run may be cut short, so it starts negative
      hi = 0;
      lo = -1000;
      hi_max = 0;
      lo_min = 1000;
      // sampled mid-cycle, away from the edge that moves scl
      repeat (200) begin
         @(negedge mclk);
         if (scl === 1'h1) begin
            if (lo > 0 && lo < lo_min) lo_min = lo;
            lo = 0;
            hi++;
            if (hi > hi_max) hi_max = hi;
         end else begin
            hi = 0;
            lo++;
         end
      end
      chk(hi_max < 11, 1'h1);
      chk(lo_min >= 11, 1'h1);
      run_clk <= 1'h0;
      sda_drive_low <= 1'h1;
      repeat (2) @(posedge mclk);
      chk(sda_oe, 1'h1);
      apb(1'h1, ies_pkg::OFS_CTRL, 32'h0);
      pulse(ev_of(ies_pkg::FL_STOP));
      apb(1'h0, ies_pkg::OFS_FLAG, 32'h0);
      chk(rd, 32'h0);
      chk({scl_oe, sda_oe, master_active, irq}, 4'h0);
      chk({scl_out, sda_out}, 2'h0);
      rst_n <= 1'h0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'h1;
      apb(1'h0, ies_pkg::OFS_ENABLE, 32'h0);
      chk(rd, 32'h0);
      stop_test();
   end
endmodule
